// >>> fsp_pkg.sv
// package for the flash self-program sequencer: encodings, map and timing
`default_nettype none
package fsp_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          PROG_MIN_US      = 3700;
    localparam int          PROG_MAX_US      = 4500;
    localparam int          PROG_CYC_DEF     = PROG_MIN_US * CLK_MHZ;
    localparam int          SPM_WINDOW       = 4;
    // control register bits
    localparam int          CTL_ENABLE_BIT   = 0;
    localparam int          CTL_ERASE_BIT    = 1;
    localparam int          CTL_WRITE_BIT    = 2;
    localparam int          CTL_BUSY_BIT     = 6;
    localparam int          CTL_REEN_BIT     = 4;
    localparam logic [7:0]  CTL_WR_MASK      = 8'h17;
    localparam logic [7:0]  CMD_FILL_VAL     = 8'h01;
    localparam logic [7:0]  CMD_ERASE_VAL    = 8'h03;
    localparam logic [7:0]  CMD_WRITE_VAL    = 8'h05;
    localparam logic [7:0]  CMD_REEN_VAL     = 8'h11;
    localparam logic [15:0] BUF_ERASED       = 16'hffff;
    // apb register offsets
    localparam logic [7:0]  REG_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  REG_PTR_OFS      = 8'h04;
    localparam logic [7:0]  REG_DATA_OFS     = 8'h08;
    localparam logic [7:0]  REG_CMD_OFS      = 8'h0c;
    localparam logic [7:0]  REG_MAP_OFS      = 8'h10;
    localparam logic [7:0]  REG_STAT_OFS     = 8'h14;
    // 8k map
    localparam logic [15:0] STALL_BASE_8K    = 16'h0c00;
    localparam logic [15:0] BOOT11_8K        = 16'h0f80;
    localparam logic [15:0] BOOT10_8K        = 16'h0f00;
    localparam logic [15:0] BOOT01_8K        = 16'h0e00;
    localparam logic [15:0] BOOT00_8K        = 16'h0c00;
    localparam logic [15:0] FLASH_END_8K     = 16'h0fff;
    // 16k map
    localparam logic [15:0] STALL_BASE_16K   = 16'h1c00;
    localparam logic [15:0] BOOT11_16K       = 16'h1f80;
    localparam logic [15:0] BOOT10_16K       = 16'h1f00;
    localparam logic [15:0] BOOT01_16K       = 16'h1e00;
    localparam logic [15:0] BOOT00_16K       = 16'h1c00;
    localparam logic [15:0] FLASH_END_16K    = 16'h1fff;
    localparam int          WORD_LSB         = 1;
    localparam int          WORD_W_8K        = 5;
    localparam int          WORD_W_16K       = 6;
    localparam int          PAGE_W           = 7;
    typedef enum logic [1:0] {
        FSP_OP_FILL  = 2'h0,
        FSP_OP_ERASE = 2'h1,
        FSP_OP_WRITE = 2'h2,
        FSP_OP_REEN  = 2'h3
    } fsp_op_t;
endpackage : fsp_pkg
`default_nettype wire

// >>> fsp_if.sv
// interface between cpu side (host) and self-program sequencer (device)
`default_nettype none
interface fsp_if;
    logic        ctl_wr;      // control register write strobe
    logic [7:0]  ctl_wdata;   // control value written
    logic [7:0]  ctl_rdata;   // control/status read back
    logic        spm_exec;    // program-store instruction strobe
    logic [15:0] ptr;         // address pointer
    logic [15:0] data_word;   // r1:r0
    logic [15:0] fetch_addr;  // word address of instruction fetch
    logic        fetch_ok;    // fetch allowed this cycle
    logic        eeprom_write_pending;
    modport dev (input ctl_wr, ctl_wdata, spm_exec, ptr, data_word, fetch_addr,
                 eeprom_write_pending, output ctl_rdata, fetch_ok);
    modport host (output ctl_wr, ctl_wdata, spm_exec, ptr, data_word, fetch_addr,
                  eeprom_write_pending, input ctl_rdata, fetch_ok);
endinterface : fsp_if
`default_nettype wire

// >>> fsp_dev.sv
// self-program sequencer: device end with page buffer, map decode and timing
// Summary of operation
// RQ1 - 8k boot size fuses pick boot start
// RQ2 - 16k boot size fuses pick boot start
// RQ3 - 8k stall region from 0xc00
// RQ4 - 16k stall region from 0x1c00
// RQ5 - 8k: 32-word pages, fields z5:1, z12:6
// RQ6 - 16k: 64-word pages, fields z6:1, z13:7
// RQ7 - pointer bits above page field ignored
// RQ8 - z0 zero for commands, byte select
// RQ9 - word field zero for page write
// RQ10 - only stall region fetchable while programming
// RQ11 - erase plus enable starts page erase
// RQ12 - enable alone loads word into buffer
// RQ13 - write plus enable programs buffer
// RQ14 - enable stays set until operation done
// RQ15 - wait eeprom idle, interrupts off
// RQ16 - busy flag cleared by re-enable command
// RQ17 - store must follow within four cycles
// RQ18 - busy flag held while region busy
// RQ19 - erase or write lasts 3.7 to 4.5 ms
// RQ20 - build parameter selects 8k or 16k
`default_nettype none
module fsp_dev
    import fsp_pkg::*;
#(
    parameter bit IS_16K   = 1'b0,                                   // RQ20
    parameter int PROG_CYC = PROG_CYC_DEF                            // RQ19
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    fsp_if.dev               bus,
    input  wire logic        boot_size_sel_hi_in,
    input  wire logic        boot_size_sel_lo_in,
    output logic [15:0]      boot_start_out,
    output logic [15:0]      app_end_out,
    output logic [15:0]      read_byte_out,
    output logic             prog_busy_out,
    output logic             page_erase_strobe_out,
    output logic             page_write_strobe_out,
    output logic [6:0]       page_sel_out
);
    localparam int WORD_W  = IS_16K ? WORD_W_16K : WORD_W_8K;            // RQ20
    localparam int DEPTH   = 1 << WORD_W;
    localparam int PAGE_LSB = WORD_LSB + WORD_W;
    localparam logic [15:0] STALL_BASE = IS_16K ? STALL_BASE_16K : STALL_BASE_8K;
    localparam logic [15:0] FLASH_END  = IS_16K ? FLASH_END_16K : FLASH_END_8K;
    localparam logic [15:0] BOOT_RESET = IS_16K ? BOOT00_16K : BOOT00_8K;

    logic [7:0]        ctl_reg;
    logic [2:0]        win_reg;
    logic              busy_reg;
    logic              rbusy_reg;
    logic [31:0]       cnt_reg;
    logic [6:0]        page_reg;
    logic              erase_p_reg;
    logic              write_p_reg;
    logic [15:0]       buf_reg [DEPTH];
    logic [15:0]       rbyte_reg;
    logic [WORD_W-1:0] word_sel;
    logic [6:0]        page_sel;
    logic              armed;
    logic [1:0]        fuse_s1_reg;
    logic [1:0]        fuse_s2_reg;
    logic [15:0]       boot_start_reg;
    logic [15:0]       boot_start_next;
    logic [15:0]       app_end_reg;

    assign word_sel = bus.ptr[WORD_LSB +: WORD_W];                      // RQ5 RQ6
    assign page_sel = bus.ptr[PAGE_LSB +: PAGE_W];                      // RQ7
    assign armed    = ctl_reg[CTL_ENABLE_BIT] && !busy_reg;

    // fuse pins come from outside the clock domain
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fuse_s1_reg <= 2'h0;
            fuse_s2_reg <= 2'h0;
        end else begin
            fuse_s1_reg <= {boot_size_sel_hi_in, boot_size_sel_lo_in};
            fuse_s2_reg <= fuse_s1_reg;
        end
    end

    always_comb begin
        case (fuse_s2_reg)
            2'b11:   boot_start_next = IS_16K ? BOOT11_16K : BOOT11_8K;  // RQ1 RQ2
            2'b10:   boot_start_next = IS_16K ? BOOT10_16K : BOOT10_8K;
            2'b01:   boot_start_next = IS_16K ? BOOT01_16K : BOOT01_8K;
            default: boot_start_next = IS_16K ? BOOT00_16K : BOOT00_8K;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_start_reg <= BOOT_RESET;
            app_end_reg    <= BOOT_RESET - 16'h0001;
        end else begin
            boot_start_reg <= boot_start_next;                            // RQ1 RQ2
            app_end_reg    <= boot_start_next - 16'h0001;
        end
    end
    assign boot_start_out = boot_start_reg;
    assign app_end_out    = app_end_reg;

    // fetch gate while programming
    always_comb begin
        bus.fetch_ok = 1'b1;
        if (busy_reg || rbusy_reg) begin
            bus.fetch_ok = (bus.fetch_addr >= STALL_BASE) &&
                           (bus.fetch_addr <= FLASH_END);                // RQ3 RQ4 RQ10
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_reg <= 8'h00;
            win_reg <= 3'h0;
        end else if (bus.ctl_wr && !ctl_reg[CTL_ENABLE_BIT] &&
                     !bus.eeprom_write_pending) begin
            ctl_reg <= bus.ctl_wdata & CTL_WR_MASK;
            win_reg <= 3'(SPM_WINDOW);
        end else if (ctl_reg[CTL_ENABLE_BIT] && !busy_reg) begin
            if (bus.spm_exec) begin
                ctl_reg <= ctl_reg[CTL_ERASE_BIT] || ctl_reg[CTL_WRITE_BIT] ?
                           ctl_reg : 8'h00;                               // RQ14
                win_reg <= 3'h0;
            end else if (win_reg <= 3'h1) begin
                ctl_reg <= 8'h00;                                         // RQ17
                win_reg <= 3'h0;
            end else begin
                win_reg <= win_reg - 3'h1;
            end
        end else if (busy_reg && cnt_reg == 32'h1) begin
            ctl_reg <= 8'h00;                                             // RQ14
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_reg    <= 1'b0;
            cnt_reg     <= 32'h0;
            page_reg    <= 7'h00;
            erase_p_reg <= 1'b0;
            write_p_reg <= 1'b0;
        end else begin
            erase_p_reg <= 1'b0;
            write_p_reg <= 1'b0;
            if (armed && bus.spm_exec &&
                (ctl_reg[CTL_ERASE_BIT] || ctl_reg[CTL_WRITE_BIT])) begin
                busy_reg    <= 1'b1;
                cnt_reg     <= 32'(PROG_CYC);                             // RQ19
                page_reg    <= page_sel;                                  // RQ11 RQ13
                erase_p_reg <= ctl_reg[CTL_ERASE_BIT];                    // RQ11
                write_p_reg <= ctl_reg[CTL_WRITE_BIT];                    // RQ13
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 32'h1;
                if (cnt_reg == 32'h1) begin
                    busy_reg <= 1'b0;
                end
            end
        end
    end

    // busy flag: set on start, cleared only by re-enable after completion
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rbusy_reg <= 1'b0;
        end else if (armed && bus.spm_exec &&
                     (ctl_reg[CTL_ERASE_BIT] || ctl_reg[CTL_WRITE_BIT])) begin
            rbusy_reg <= 1'b1;                                            // RQ18
        end else if (armed && bus.spm_exec && ctl_reg[CTL_REEN_BIT]) begin
            rbusy_reg <= 1'b0;                                            // RQ16
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_buf
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    buf_reg[gi] <= BUF_ERASED;
                end else if (armed && bus.spm_exec &&
                             ctl_reg[7:1] == 7'h00 &&
                             word_sel == WORD_W'(gi)) begin
                    buf_reg[gi] <= bus.data_word;                         // RQ12
                end else if (write_p_reg) begin
                    buf_reg[gi] <= BUF_ERASED;
                end
            end
        end
    endgenerate

    // buffer read-back with z0 as byte select
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rbyte_reg <= 16'h0000;
        end else begin
            rbyte_reg <= bus.ptr[0] ? {8'h00, buf_reg[word_sel][15:8]}
                                    : {8'h00, buf_reg[word_sel][7:0]};    // RQ8
        end
    end

    always_comb begin
        bus.ctl_rdata = ctl_reg;
        bus.ctl_rdata[CTL_BUSY_BIT] = rbusy_reg;                          // RQ16
    end
    assign read_byte_out         = rbyte_reg;
    assign prog_busy_out         = busy_reg;
    assign page_erase_strobe_out = erase_p_reg;
    assign page_write_strobe_out = write_p_reg;
    assign page_sel_out          = page_reg;
endmodule : fsp_dev
`default_nettype wire

// >>> fsp_host.sv
// cpu-side end: apb registers, command sequencing toward the sequencer
`default_nettype none
module fsp_host
    import fsp_pkg::*;
#(
    parameter bit IS_16K = 1'b0
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        eeprom_write_pending_in,
    fsp_if.host              bus
);
    localparam int WORD_W = IS_16K ? WORD_W_16K : WORD_W_8K;
    typedef enum logic [1:0] {
        FSP_H_IDLE  = 2'h0,
        FSP_H_POLL  = 2'h1,
        FSP_H_WRITE = 2'h2,
        FSP_H_STORE = 2'h3
    } fsp_hst_t;

    fsp_hst_t    st_reg;
    logic [15:0] ptr_reg;
    logic [15:0] data_reg;
    logic [1:0]  op_reg;
    logic        ee_s1_reg;
    logic        ee_s2_reg;
    logic        wr_reg;
    logic        exec_reg;
    logic [7:0]  wval_reg;
    logic [31:0] rdata_reg;
    logic        acc;
    logic        go;

    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign go      = acc && pwrite && paddr == REG_CMD_OFS && st_reg == FSP_H_IDLE;
    assign pslverr = acc && !(paddr == REG_CTRL_OFS || paddr == REG_PTR_OFS ||
                     paddr == REG_DATA_OFS || paddr == REG_CMD_OFS ||
                     paddr == REG_STAT_OFS);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ee_s1_reg <= 1'b0;
            ee_s2_reg <= 1'b0;
        end else begin
            ee_s1_reg <= eeprom_write_pending_in;
            ee_s2_reg <= ee_s1_reg;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_reg  <= 16'h0000;
            data_reg <= 16'h0000;
            op_reg   <= 2'h0;
        end else if (acc && pwrite) begin
            if (paddr == REG_PTR_OFS) begin
                ptr_reg <= pwdata[15:0];                                  // RQ8
            end
            if (paddr == REG_DATA_OFS) begin
                data_reg <= pwdata[15:0];
            end
            if (go) begin
                op_reg <= pwdata[1:0];
            end
        end else if (st_reg == FSP_H_STORE && op_reg == FSP_OP_WRITE) begin
            ptr_reg[WORD_LSB +: WORD_W] <= '0;                            // RQ9
        end
    end

    // poll enable, wait eeprom idle, write control, store next cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg   <= FSP_H_IDLE;
            wr_reg   <= 1'b0;
            exec_reg <= 1'b0;
            wval_reg <= 8'h00;
        end else begin
            wr_reg   <= 1'b0;
            exec_reg <= 1'b0;
            case (st_reg)
                FSP_H_IDLE: begin
                    if (go) begin
                        st_reg <= FSP_H_POLL;
                    end
                end
                FSP_H_POLL: begin
                    if (!bus.ctl_rdata[CTL_ENABLE_BIT] && !ee_s2_reg) begin  // RQ14 RQ15
                        st_reg <= FSP_H_WRITE;
                    end
                end
                FSP_H_WRITE: begin
                    wr_reg <= 1'b1;
                    unique case (fsp_op_t'(op_reg))
                        FSP_OP_ERASE: wval_reg <= CMD_ERASE_VAL;          // RQ11
                        FSP_OP_WRITE: wval_reg <= CMD_WRITE_VAL;          // RQ13
                        FSP_OP_REEN:  wval_reg <= CMD_REEN_VAL;           // RQ16
                        default:      wval_reg <= CMD_FILL_VAL;           // RQ12
                    endcase
                    st_reg <= FSP_H_STORE;
                end
                FSP_H_STORE: begin
                    exec_reg <= 1'b1;                                     // RQ17
                    st_reg   <= FSP_H_IDLE;
                end
                default: st_reg <= FSP_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h0;
        end else begin
            unique case (paddr)
                REG_CTRL_OFS: rdata_reg <= {24'h0, bus.ctl_rdata};
                REG_PTR_OFS:  rdata_reg <= {16'h0, ptr_reg};
                REG_DATA_OFS: rdata_reg <= {16'h0, data_reg};
                REG_STAT_OFS: rdata_reg <= {30'h0, st_reg};
                default:      rdata_reg <= 32'h0;
            endcase
        end
    end
    assign prdata = rdata_reg;

    assign bus.ctl_wr               = wr_reg;
    assign bus.ctl_wdata            = wval_reg;
    assign bus.spm_exec             = exec_reg;
    assign bus.ptr                  = ptr_reg;
    assign bus.data_word            = data_reg;
    assign bus.fetch_addr           = ptr_reg;
    assign bus.eeprom_write_pending = ee_s2_reg;
endmodule : fsp_host
`default_nettype wire

// >>> fsp_link_props.sv
// checker on the host-to-sequencer link of the 8k pair
`default_nettype none
module fsp_link_props
    import fsp_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ctl_wr,
    input  wire logic [7:0]  ctl_wdata,
    input  wire logic [7:0]  ctl_rdata,
    input  wire logic        spm_exec,
    input  wire logic [15:0] ptr,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        fetch_ok,
    input  wire logic        eeprom_write_pending
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire logic rbusy = ctl_rdata[CTL_BUSY_BIT];
    // store issued while an erase or write is armed
    sequence s_prog_start;
        spm_exec && (ctl_rdata[CTL_ERASE_BIT] || ctl_rdata[CTL_WRITE_BIT]);
    endsequence
    sequence s_armed;
        ctl_wr && ctl_wdata[CTL_ENABLE_BIT];
    endsequence
    AST_SPM_FOLLOWS: assert property (s_armed |-> ##[1:4] spm_exec)
        else $error("store did not follow the control write");
    AST_NO_CMD_ENABLED: assert property (ctl_wr |-> !ctl_rdata[CTL_ENABLE_BIT])
        else $error("command issued while enable still set");
    AST_NO_CMD_EEPROM: assert property (
        eeprom_write_pending && $past(eeprom_write_pending) |-> !ctl_wr)
        else $error("command issued during eeprom write");
    AST_ENABLE_HELD: assert property (s_prog_start |=> ctl_rdata[CTL_ENABLE_BIT] [*8])
        else $error("enable cleared before operation end");
    AST_BUSY_RISES: assert property (s_prog_start |-> ##[1:3] rbusy)
        else $error("region busy flag not set");
    AST_BUSY_CLEAR_CAUSE: assert property (
        $fell(rbusy) |-> $past(ctl_rdata[CTL_REEN_BIT]) || $past(spm_exec))
        else $error("busy flag cleared without re-enable");
    AST_RWW_BLOCKED: assert property (
        rbusy && fetch_addr < STALL_BASE_8K |-> !fetch_ok)
        else $error("fetch from busy region allowed");
    AST_STALL_FETCH: assert property (
        fetch_addr >= STALL_BASE_8K && fetch_addr <= FLASH_END_8K |-> fetch_ok)
        else $error("fetch from stall region refused");
    AST_IDLE_FETCH: assert property (
        !rbusy && !ctl_rdata[CTL_ENABLE_BIT] |-> fetch_ok)
        else $error("fetch refused while idle");
    AST_Z0_ZERO: assert property (spm_exec |-> !ptr[0])
        else $error("pointer bit 0 set at store");
    AST_WORD_ZERO: assert property (
        spm_exec && ctl_rdata[CTL_WRITE_BIT] |-> ptr[5:1] == 5'h00)
        else $error("word field not zero at page write");
endmodule : fsp_link_props
`default_nettype wire

// >>> flash_self_program_sequencer_bench.sv
// bench: apb-driven host and sequencer pairs for the 8k and 16k builds
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module flash_self_program_sequencer_bench
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 20;
    logic        ref_clk_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic        eep        = 1'b0;
    logic        hi         = 1'b1;
    logic        lo         = 1'b1;
    logic [15:0] boot_s [2];
    logic [15:0] app_s  [2];
    logic [15:0] rbyte_s[2];
    logic        busy_s [2];
    logic        ers_s  [2];
    logic        wrs_s  [2];
    logic [6:0]  pg_s   [2];
    logic [31:0] prd_s  [2];
    logic        rdy_s  [2];
    logic        err_s  [2];
    logic [31:0] rdata;
    logic        rerr;
    logic [14:0] e;
    logic [14:0] exp_q[$];
    logic [15:0] p;
    logic [15:0] d;
    logic [4:0]  w;
    int          seed;
    int          blen = 0;
    int          bad_count = 0;
    int          check_count = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    for (genvar i = 0; i < 2; i++) begin : g_pair
        fsp_if u_if ();
        fsp_host #(.IS_16K(i == 1)) u_fsp_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
            .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
            .prdata(prd_s[i]), .pready(rdy_s[i]), .pslverr(err_s[i]),
            .eeprom_write_pending_in(eep), .bus(u_if));
        fsp_dev #(.IS_16K(i == 1), .PROG_CYC(PC)) u_fsp_dev (.ref_clk_in(ref_clk_in),
            .rst_in(rst_in), .bus(u_if), .boot_size_sel_hi_in(hi), .boot_size_sel_lo_in(lo),
            .boot_start_out(boot_s[i]), .app_end_out(app_s[i]), .read_byte_out(rbyte_s[i]),
            .prog_busy_out(busy_s[i]), .page_erase_strobe_out(ers_s[i]),
            .page_write_strobe_out(wrs_s[i]), .page_sel_out(pg_s[i]));
    end
    fsp_link_props u_fsp_link_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .ctl_wr(g_pair[0].u_if.ctl_wr), .ctl_wdata(g_pair[0].u_if.ctl_wdata),
        .ctl_rdata(g_pair[0].u_if.ctl_rdata), .spm_exec(g_pair[0].u_if.spm_exec),
        .ptr(g_pair[0].u_if.ptr), .fetch_addr(g_pair[0].u_if.fetch_addr),
        .fetch_ok(g_pair[0].u_if.fetch_ok),
        .eeprom_write_pending(g_pair[0].u_if.eeprom_write_pending));
    // start strobes checked against the oldest noted page
    always @(posedge ref_clk_in) begin
        if (ers_s[0] === 1'b1 || wrs_s[0] === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("wrong value at %0t: unexpected start", $time);
            end else begin
                e = exp_q.pop_front();
                `CHK(wrs_s[0], e[14])
                `CHK(ers_s[0], ~e[14])
                `CHK(pg_s[0], e[13:7])
                `CHK(pg_s[1], e[6:0])
                `CHK(ers_s[1] | wrs_s[1], 1'b1)
            end
        end
        if (busy_s[0] === 1'b1) begin
            blen++;
        end else if (blen != 0) begin
            `CHK(blen, PC)
            blen = 0;
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (rdy_s[0] !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            stop_test();
        end
        rdata = prd_s[0];
        rerr = err_s[0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input fsp_op_t op, input logic [15:0] pv);
        apb(1'b1, REG_PTR_OFS, {16'h0, pv});
        apb(1'b1, REG_CMD_OFS, 32'(op));
    endtask : cmd
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (busy_s[0] !== 1'b1 && n < lim) begin
            @(posedge ref_clk_in);
            n++;
        end
        `CHK(n < lim, 1'b1)
        if (n >= lim) stop_test();
        n = 0;
        do begin
            apb(1'b0, REG_CTRL_OFS, 32'h0);
            n++;
            if (n == 1) `CHK(rdata[CTL_ENABLE_BIT], 1'b1)
        end while (rdata[CTL_ENABLE_BIT] !== 1'b0 && n < 40);
        `CHK(rdata[CTL_ENABLE_BIT], 1'b0)
        if (rdata[CTL_ENABLE_BIT] !== 1'b0) stop_test();
        `CHK(rdata[CTL_BUSY_BIT], 1'b1)
        `CHK(busy_s[0], 1'b0)
    endtask : wait_done
    task automatic reenable();
        cmd(FSP_OP_REEN, 16'h0);
        repeat (10) @(posedge ref_clk_in);
        apb(1'b0, REG_CTRL_OFS, 32'h0);
        `CHK(rdata[CTL_BUSY_BIT], 1'b0)
    endtask : reenable
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        bad_count++;
        stop_test();
    end
    initial begin
        seed = 8225;
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            {hi, lo} <= c[1:0];
            repeat (5) @(posedge ref_clk_in);
            `CHK(boot_s[0], 16'h1000 - (16'h0080 << (3 - c)))
            `CHK(app_s[0], 16'h0fff - (16'h0080 << (3 - c)))
            `CHK(boot_s[1], 16'h2000 - (16'h0080 << (3 - c)))
            `CHK(app_s[1], 16'h1fff - (16'h0080 << (3 - c)))
        end
        $display("test fuse decode done");
        apb(1'b0, 8'h20, 32'h0);
        `CHK(rerr, 1'b1)
        apb(1'b0, REG_STAT_OFS, 32'h0);
        `CHK(rerr, 1'b0)
        for (int k = 0; k < 3; k++) begin
            w = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($random(seed));
            d = 16'($random(seed));
            apb(1'b1, REG_DATA_OFS, {16'h0, d});
            apb(1'b0, REG_DATA_OFS, 32'h0);
            `CHK(rdata, {16'h0, d})
            cmd(FSP_OP_FILL, {10'h0, w, 1'b0});
            repeat (10) @(posedge ref_clk_in);
            apb(1'b1, REG_PTR_OFS, {26'h0, w, 1'b1});
            repeat (4) @(posedge ref_clk_in);
            `CHK(rbyte_s[0][7:0], d[15:8])
            `CHK(rbyte_s[1][7:0], d[15:8])
            apb(1'b1, REG_PTR_OFS, {26'h0, w, 1'b0});
            repeat (4) @(posedge ref_clk_in);
            `CHK(rbyte_s[0][7:0], d[7:0])
        end
        $display("test buffer fill done");
        for (int k = 0; k < 3; k++) begin
            p = 16'($random(seed)) & 16'hfffe;
            apb(1'b1, REG_MAP_OFS, {20'h0, p[11:0]});
            eep <= (k == 2);
            exp_q.push_back({1'b0, p[12:6], p[13:7]});
            cmd(FSP_OP_ERASE, p);
            if (k == 2) begin
                repeat (30) @(posedge ref_clk_in);
                `CHK(busy_s[0], 1'b0)
                eep <= 1'b0;
            end
            wait_done(60);
            reenable();
            exp_q.push_back({1'b1, p[12:6], p[13:7]});
            cmd(FSP_OP_WRITE, p);
            wait_done(40);
            `CHK(rbyte_s[0][7:0], 8'hff)
            reenable();
        end
        $display("test erase and write done");
        `CHK(exp_q.size(), 0)
        stop_test();
    end
endmodule : flash_self_program_sequencer_bench
`default_nettype wire
